// ===== logic/pcs_socket_ctrl.sv
// Register bank and socket control outputs for two PC Card sockets
`timescale 1ns/1ps
module pcs_socket_ctrl
  import pcs_pkg::*;
#(
  parameter int SOCKETS = 2
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic [7:0]         addr,
  input  wire logic [7:0]         wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [7:0]              rdata,
  input  wire logic [SOCKETS-1:0] card_detect,
  input  wire logic [SOCKETS-1:0] system_socket_power_bit,
  input  wire logic [SOCKETS-1:0] battery_detect_ring_pin,
  input  wire logic [SOCKETS-1:0] card_is_32bit,
  input  wire logic [SOCKETS-1:0] functional_irq_in,
  input  wire logic [SOCKETS-1:0] status_change_in,
  output logic [SOCKETS-1:0]      card_output_enable,
  output logic [SOCKETS-1:0]      card_reset,
  output logic [SOCKETS-1:0]      vcc_on,
  output logic [SOCKETS-1:0]      vcc_3v,
  output logic [SOCKETS-1:0]      vpp_vcc,
  output logic [SOCKETS-1:0]      vpp_12v,
  output logic [SOCKETS-1:0]      ring_indicate,
  output logic [SOCKETS-1:0]      io_card_mode,
  output logic [SOCKETS-1:0]      csc_to_host,
  output logic [SOCKETS-1:0]      csc_to_legacy,
  output logic [SOCKETS*4-1:0]    func_irq_line,
  output logic [SOCKETS-1:0]      func_irq_smi
);

  // Socket number from the index, sockets spaced by 40h
  function automatic int sock_of(input logic [7:0] a);
    return (a & PCS_IDX_SOCK_B) != 8'h00 ? 1 : 0;
  endfunction

  // Writable mask of the power register for the active layout
  function automatic logic [7:0] pwr_mask(input logic [3:0] rev);
    return (rev == PCS_REV_OLD_MODE) ? PCS_PWR_MASK_OLD : PCS_PWR_MASK_NEW;
  endfunction

  logic [7:0] power_reg [SOCKETS];
  logic [7:0] intctl_reg [SOCKETS];
  logic [3:0] rev_reg [SOCKETS];
  logic [7:0] next_power_reg [SOCKETS];
  logic [7:0] next_intctl_reg [SOCKETS];
  logic [3:0] next_rev_reg [SOCKETS];
  logic [7:0] next_rdata;
  logic [7:0] loc;
  int         sk;

  // Register writes and read mux
  always_comb begin
    loc = addr & PCS_IDX_MASK;
    sk = sock_of(addr);
    next_rdata = PCS_RESET_VALUE;
    for (int i = 0; i < SOCKETS; i++) begin
      next_power_reg[i] = power_reg[i];
      next_intctl_reg[i] = intctl_reg[i];
      next_rev_reg[i] = rev_reg[i];
    end
    if (wr && sk < SOCKETS) begin
      case (loc)
        PCS_IDX_IDENT: next_rev_reg[sk] = wdata[3:0];
        PCS_IDX_POWER: next_power_reg[sk] = wdata & pwr_mask(rev_reg[sk]);
        PCS_IDX_INTCTL: next_intctl_reg[sk] = wdata;
        default: ;
      endcase
    end
    if (rd && sk < SOCKETS) begin
      case (loc)
        PCS_IDX_IDENT: next_rdata = {PCS_IDENT_TYPE, 2'h0, rev_reg[sk]};
        // Mask again on read so a mode change never exposes stale reserved bits
        PCS_IDX_POWER: next_rdata = power_reg[sk] & pwr_mask(rev_reg[sk]);
        PCS_IDX_INTCTL: next_rdata = intctl_reg[sk];
        default: next_rdata = PCS_RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= PCS_RESET_VALUE;
      for (int i = 0; i < SOCKETS; i++) begin
        power_reg[i] <= PCS_RESET_VALUE;
        intctl_reg[i] <= PCS_RESET_VALUE;
        rev_reg[i] <= PCS_REV_RESET;
      end
    end else begin
      rdata <= next_rdata;
      for (int i = 0; i < SOCKETS; i++) begin
        power_reg[i] <= next_power_reg[i];
        intctl_reg[i] <= next_intctl_reg[i];
        rev_reg[i] <= next_rev_reg[i];
      end
    end
  end

  // Socket-side decode, registered so every output comes from a flop
  logic [SOCKETS-1:0]   n_oe, n_rst, n_von, n_v3, n_pvcc, n_p12, n_ri, n_io, n_host, n_leg, n_smi;
  logic [SOCKETS*4-1:0] n_line;

  always_comb begin
    logic        old_mode;
    logic        supply;
    logic        host_route;
    logic [3:0]  sel;
    pcs_vpp_type vpp;
    pcs_vcc_type vcc;
    old_mode = 1'b0;
    supply = 1'b0;
    sel = PCS_SEL_NONE;
    vpp = PCS_VPP_OFF;
    vcc = PCS_VCC_0V;
    host_route = 1'b0;
    // Defaults keep every bit assigned even if the socket count shrinks
    n_oe = '0;
    n_rst = '0;
    n_von = '0;
    n_v3 = '0;
    n_pvcc = '0;
    n_p12 = '0;
    n_ri = '0;
    n_io = '0;
    n_host = '0;
    n_leg = '0;
    n_smi = '0;
    n_line = '0;
    for (int i = 0; i < SOCKETS; i++) begin
      old_mode = (rev_reg[i] == PCS_REV_OLD_MODE);
      vcc = pcs_vcc_type'(power_reg[i][PCS_VCC_LSB +: 2]);
      vpp = pcs_vpp_type'(power_reg[i][PCS_VPP_LSB +: 2]);
      if (old_mode) begin
        // Auto switching follows card detects, else supply on request only
        supply = power_reg[i][PCS_BIT_PWREN] && system_socket_power_bit[i]
                 && (!power_reg[i][PCS_BIT_AUTO] || card_detect[i]);
        n_v3[i] = 1'b0;
      end else begin
        supply = (vcc == PCS_VCC_5V) || (vcc == PCS_VCC_3V);
        n_v3[i] = (vcc == PCS_VCC_3V);
      end
      n_von[i] = supply;
      // Reserved code 11 falls through to no connection
      n_pvcc[i] = supply && (vpp == PCS_VPP_VCC);
      n_p12[i] = supply && (vpp == PCS_VPP_12V);
      n_oe[i] = power_reg[i][PCS_BIT_OE];
      n_rst[i] = !intctl_reg[i][PCS_BIT_NRESET] && !card_is_32bit[i];
      n_ri[i] = intctl_reg[i][PCS_BIT_RING] && battery_detect_ring_pin[i];
      n_io[i] = intctl_reg[i][PCS_BIT_IOCARD];
      sel = intctl_reg[i][PCS_SEL_LSB +: PCS_SEL_WIDTH];
      // Select code zero keeps the host route open for older drivers
      host_route = intctl_reg[i][PCS_BIT_HOST_ROUTE] || (sel == PCS_SEL_NONE);
      n_host[i] = status_change_in[i] && host_route;
      n_leg[i] = status_change_in[i] && !host_route;
      n_smi[i] = functional_irq_in[i] && n_io[i] && sel == PCS_SEL_SMI;
      n_line[i*4 +: 4] = (functional_irq_in[i] && n_io[i] && sel != PCS_SEL_SMI) ? sel : PCS_SEL_NONE;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      card_output_enable <= '0;
      card_reset <= '1;
      vcc_on <= '0;
      vcc_3v <= '0;
      vpp_vcc <= '0;
      vpp_12v <= '0;
      ring_indicate <= '0;
      io_card_mode <= '0;
      csc_to_host <= '0;
      csc_to_legacy <= '0;
      func_irq_line <= '0;
      func_irq_smi <= '0;
    end else begin
      card_output_enable <= n_oe;
      card_reset <= n_rst;
      vcc_on <= n_von;
      vcc_3v <= n_v3;
      vpp_vcc <= n_pvcc;
      vpp_12v <= n_p12;
      ring_indicate <= n_ri;
      io_card_mode <= n_io;
      csc_to_host <= n_host;
      csc_to_legacy <= n_leg;
      func_irq_line <= n_line;
      func_irq_smi <= n_smi;
    end
  end

  // Output enable tracks its register bit one cycle later
  a_oe_follows: assert property (@(posedge clk) disable iff (reset)
    card_output_enable[0] == $past(power_reg[0][PCS_BIT_OE]))
    else $error("output enable does not follow register");

  // Second socket keeps its own copy of the enable
  a_oe_follows_b: assert property (@(posedge clk) disable iff (reset)
    card_output_enable[1] == $past(power_reg[1][PCS_BIT_OE]))
    else $error("second socket output enable does not follow register");

  // Vpp never on while logic supply is off
  a_vpp_needs_vcc: assert property (@(posedge clk) disable iff (reset)
    !vcc_on[0] |-> !vpp_vcc[0] && !vpp_12v[0])
    else $error("vpp driven without vcc");

  // Reserved code must not switch either programming supply
  a_vpp_reserved: assert property (@(posedge clk) disable iff (reset)
    power_reg[0][PCS_VPP_LSB +: 2] == PCS_VPP_RSVD |=> !vpp_vcc[0] && !vpp_12v[0])
    else $error("reserved vpp code switched a supply");

  // Old layout reads zeros outside its writable bits
  a_read_reserved: assert property (@(posedge clk) disable iff (reset)
    rd && (addr & PCS_IDX_MASK) == PCS_IDX_POWER && (addr & PCS_IDX_SOCK_B) == 8'h00
    && rev_reg[0] == PCS_REV_OLD_MODE |=> (rdata & ~PCS_PWR_MASK_OLD) == 8'h00)
    else $error("reserved power bits read nonzero");

  // New layout reads zeros outside its writable bits
  a_read_rsvd_new: assert property (@(posedge clk) disable iff (reset)
    rd && (addr & PCS_IDX_MASK) == PCS_IDX_POWER && (addr & PCS_IDX_SOCK_B) == 8'h00
    && rev_reg[0] != PCS_REV_OLD_MODE |=> (rdata & ~PCS_PWR_MASK_NEW) == 8'h00)
    else $error("reserved power bits read nonzero in new layout");

  // 16-bit card held in reset while the release bit is clear
  a_reset_bit: assert property (@(posedge clk) disable iff (reset)
    !intctl_reg[0][PCS_BIT_NRESET] && !card_is_32bit[0] |=> card_reset[0])
    else $error("card reset not asserted");

  // Setting the release bit lets the card run
  a_reset_release: assert property (@(posedge clk) disable iff (reset)
    intctl_reg[0][PCS_BIT_NRESET] |=> !card_reset[0])
    else $error("card reset not released");

  // Wide cards lose the 16-bit reset from the next cycle on, except during bank reset
  a_wide_card: assert property (@(posedge clk) disable iff (reset)
    card_is_32bit[1] |=> !card_reset[1])
    else $error("card reset driven to a wide card");

  // Zero select keeps status changes on the host lines
  a_host_route: assert property (@(posedge clk) disable iff (reset)
    status_change_in[0] && intctl_reg[0][PCS_SEL_LSB +: PCS_SEL_WIDTH] == PCS_SEL_NONE |=> csc_to_host[0])
    else $error("status change not routed to host");

  // Route bit alone forces the host lines
  a_route_bit: assert property (@(posedge clk) disable iff (reset)
    status_change_in[0] && intctl_reg[0][PCS_BIT_HOST_ROUTE] |=> csc_to_host[0] && !csc_to_legacy[0])
    else $error("route bit did not select host lines");

  // Route bit clear with a live select goes to the legacy lines
  a_legacy_route: assert property (@(posedge clk) disable iff (reset)
    status_change_in[0] && !intctl_reg[0][PCS_BIT_HOST_ROUTE]
    && intctl_reg[0][PCS_SEL_LSB +: PCS_SEL_WIDTH] != PCS_SEL_NONE |=> csc_to_legacy[0] && !csc_to_host[0])
    else $error("status change not routed to legacy lines");

  // Management code raises its own flag and no numbered line
  a_smi_route: assert property (@(posedge clk) disable iff (reset)
    functional_irq_in[0] && intctl_reg[0][PCS_BIT_IOCARD] && intctl_reg[0][PCS_SEL_LSB +: PCS_SEL_WIDTH] == PCS_SEL_SMI
    |=> func_irq_smi[0] && func_irq_line[PCS_SEL_WIDTH-1:0] == PCS_SEL_NONE)
    else $error("management interrupt not routed");

  // Other codes show up as the numbered line
  a_line_route: assert property (@(posedge clk) disable iff (reset)
    functional_irq_in[0] && intctl_reg[0][PCS_BIT_IOCARD] && intctl_reg[0][PCS_SEL_LSB +: PCS_SEL_WIDTH] != PCS_SEL_SMI
    |=> func_irq_line[PCS_SEL_WIDTH-1:0] == $past(intctl_reg[0][PCS_SEL_LSB +: PCS_SEL_WIDTH]))
    else $error("functional interrupt on wrong line");

  // Write then read of the first control register, back to back
  sequence s_ctl_write;
    wr && addr == PCS_IDX_INTCTL;
  endsequence

  sequence s_ctl_read;
    rd && addr == PCS_IDX_INTCTL;
  endsequence

  a_write_reads: assert property (@(posedge clk) disable iff (reset)
    s_ctl_write ##1 s_ctl_read |=> rdata == $past(wdata, 2))
    else $error("control register readback mismatch");

  // Read data only stand in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    !rd |=> rdata == PCS_RESET_VALUE)
    else $error("read data present without a read");

  // New layout code 11 gives the low supply
  a_vcc_3v: assert property (@(posedge clk) disable iff (reset)
    rev_reg[1] != PCS_REV_OLD_MODE && power_reg[1][PCS_VCC_LSB +: 2] == PCS_VCC_3V |=> vcc_3v[1] && vcc_on[1])
    else $error("3 V request not honoured");

  // New layout codes 00 and 01 keep the supply off
  a_vcc_off_code: assert property (@(posedge clk) disable iff (reset)
    rev_reg[0] != PCS_REV_OLD_MODE && !power_reg[0][PCS_VCC_LSB + 1] |=> !vcc_on[0])
    else $error("supply on for an off code");

  // Old layout with enable clear leaves the supply open
  a_old_no_supply: assert property (@(posedge clk) disable iff (reset)
    rev_reg[0] == PCS_REV_OLD_MODE && !power_reg[0][PCS_BIT_PWREN] |=> !vcc_on[0])
    else $error("supply on with enable clear");

  // Auto switching drops the supply when no card is seen
  a_auto_no_card: assert property (@(posedge clk) disable iff (reset)
    rev_reg[0] == PCS_REV_OLD_MODE && power_reg[0][PCS_BIT_AUTO] && !card_detect[0] |=> !vcc_on[0])
    else $error("auto switch powered an empty socket");

  // Ring input ignored while the enable is clear
  a_ring_off: assert property (@(posedge clk) disable iff (reset)
    !intctl_reg[0][PCS_BIT_RING] |=> !ring_indicate[0])
    else $error("ring indicate active while disabled");

  // Ring input passes once enabled
  a_ring_on: assert property (@(posedge clk) disable iff (reset)
    intctl_reg[0][PCS_BIT_RING] && battery_detect_ring_pin[0] |=> ring_indicate[0])
    else $error("ring indicate lost while enabled");

endmodule

// ===== logic/pcs_pkg.sv
// Constants and types for the PC Card socket power and interrupt control bank
package pcs_pkg;
  localparam logic [7:0] PCS_IDX_MASK      = 8'h3F;
  localparam logic [7:0] PCS_IDX_SOCK_B    = 8'h40;
  localparam logic [7:0] PCS_IDX_IDENT     = 8'h00;
  localparam logic [7:0] PCS_IDX_POWER     = 8'h02;
  localparam logic [7:0] PCS_IDX_INTCTL    = 8'h03;
  localparam logic [7:0] PCS_RESET_VALUE   = 8'h00;
  localparam logic [3:0] PCS_REV_RESET     = 4'h4;
  localparam logic [3:0] PCS_REV_OLD_MODE  = 4'h2;
  localparam logic [1:0] PCS_IDENT_TYPE    = 2'h2;
  // Writable bits of the power register per layout
  localparam logic [7:0] PCS_PWR_MASK_OLD  = 8'hB3;
  localparam logic [7:0] PCS_PWR_MASK_NEW  = 8'h9B;
  localparam int PCS_BIT_OE        = 7;
  localparam int PCS_BIT_AUTO      = 5;
  localparam int PCS_BIT_PWREN     = 4;
  localparam int PCS_VCC_LSB       = 3;
  localparam int PCS_VPP_LSB       = 0;
  localparam int PCS_BIT_RING      = 7;
  localparam int PCS_BIT_NRESET    = 6;
  localparam int PCS_BIT_IOCARD    = 5;
  localparam int PCS_BIT_HOST_ROUTE = 4;
  localparam int PCS_SEL_LSB       = 0;
  localparam int PCS_SEL_WIDTH     = 4;
  localparam logic [3:0] PCS_SEL_NONE = 4'h0;
  localparam logic [3:0] PCS_SEL_SMI  = 4'h2;
  typedef enum logic [1:0] {PCS_VPP_OFF, PCS_VPP_VCC, PCS_VPP_12V, PCS_VPP_RSVD} pcs_vpp_type;
  typedef enum logic [1:0] {PCS_VCC_0V, PCS_VCC_0V_RSVD, PCS_VCC_5V, PCS_VCC_3V} pcs_vcc_type;
endpackage

// ===== tb/pcs_card_model.sv
// Behavioural card seated in each socket, 16-bit unless the bench marks it wide
`timescale 1ns/1ps
module pcs_card_model (
  input  wire logic       clk,
  input  wire logic [1:0] seated,
  input  wire logic [1:0] ring_level,
  input  wire logic [1:0] card_reset,
  input  wire logic [1:0] wide_card,
  output logic [1:0]      card_detect,
  output logic [1:0]      battery_detect_ring_pin,
  output logic [1:0]      card_is_32bit,
  output logic [1:0]      functional_irq_in,
  output logic [1:0]      status_change_in
);
  // Levels move one edge after a change, like a card settling
  always @(posedge clk) begin
    card_detect <= seated;
    battery_detect_ring_pin <= ring_level & seated;
    functional_irq_in <= seated & ~card_reset;  // Quiet while held in reset
    status_change_in <= seated;
  end
  // Bench chooses which sockets hold a wide card
  assign card_is_32bit = wide_card;
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the socket control bank
`timescale 1ns/1ps
module tb_top;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] got;
  logic [7:0] fline;
  logic [1:0] seated = 2'h3;
  logic [1:0] ring = 2'h0;
  logic [1:0] sysp = 2'h0;
  logic [1:0] wide = 2'h0;
  logic [1:0] cd, bat, c32, fin, scin, oe, crst, von, v3, vpv, vp12, ri, io, csh, csl, smi;
  logic [7:0] iv [5] = '{8'hC0, 8'h73, 8'h63, 8'h40, 8'h4F};
  logic [8:0] ie [5] = '{9'h140, 9'h0C3, 9'h0A3, 9'h040, 9'h020};
  int         fails = 0;
  int         n_checks = 0;
  always #25 clk = ~clk;
  pcs_socket_ctrl #(.SOCKETS(2)) dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .card_detect(cd), .system_socket_power_bit(sysp),
    .battery_detect_ring_pin(bat), .card_is_32bit(c32), .functional_irq_in(fin),
    .status_change_in(scin), .card_output_enable(oe), .card_reset(crst), .vcc_on(von),
    .vcc_3v(v3), .vpp_vcc(vpv), .vpp_12v(vp12), .ring_indicate(ri), .io_card_mode(io),
    .csc_to_host(csh), .csc_to_legacy(csl), .func_irq_line(fline), .func_irq_smi(smi));
  pcs_card_model card_u (.clk(clk), .seated(seated), .ring_level(ring), .card_reset(crst), .wide_card(wide),
    .card_detect(cd), .battery_detect_ring_pin(bat), .card_is_32bit(c32),
    .functional_irq_in(fin), .status_change_in(scin));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  // Write then read with no idle cycle between the strobes
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  // Outputs lag the registers, so let them land
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Watchdog far beyond the roughly 150 cycles the tests need
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    sysp <= 2'h3;
    rchk(8'h02, 8'h00);
    rchk(8'h43, 8'h00);
    chk({14'h0, crst}, 16'h0003);
    wreg(8'h03, 8'h40);
    rchk(8'h03, 8'h40);
    rchk(8'h43, 8'h00);
    rchk(8'h07, 8'h00);
    settle;
    chk({14'h0, crst}, 16'h0002);
    @(posedge clk);
    wide <= 2'h2;
    settle;
    chk({14'h0, crst}, 16'h0000);
    @(posedge clk);
    wide <= 2'h0;
    $display("test reset and sockets done");
    wreg(8'h42, 8'hFF);
    rchk(8'h42, 8'h9B);
    rchk(8'h02, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wreg(8'h02, 8'h80 | 8'(c << 3));
      settle;
      chk({13'h0, oe[0], von[0], v3[0]}, {13'h0, 1'b1, c[1], c == 3});
    end
    for (int v = 0; v < 4; v++) begin
      wreg(8'h02, 8'h90 | 8'(v));
      settle;
      chk({14'h0, vpv[0], vp12[0]}, {14'h0, v == 1, v == 2});
    end
    wreg(8'h02, 8'h02);
    settle;
    chk({13'h0, oe[0], vpv[0], vp12[0]}, 16'h0000);
    $display("test second layout done");
    wreg(8'h00, 8'h02);
    wreg(8'h02, 8'hFF);
    rchk(8'h02, 8'hB3);
    wreg(8'h02, 8'h10);
    settle;
    chk({15'h0, von[0]}, 16'h0001);
    wreg(8'h02, 8'h30);
    @(posedge clk);
    seated <= 2'h2;
    settle;
    chk({15'h0, von[0]}, 16'h0000);
    wreg(8'h02, 8'h00);
    seated <= 2'h3;
    settle;
    chk({15'h0, von[0]}, 16'h0000);
    $display("test first layout done");
    @(posedge clk);
    ring <= 2'h3;
    for (int i = 0; i < 5; i++) begin
      wrrd(8'h03, iv[i], iv[i]);
      settle;
      chk({7'h0, ri[0], io[0], csh[0], csl[0], smi[0], fline[3:0]}, {7'h0, ie[i]});
    end
    wreg(8'h03, 8'h62);
    settle;
    chk({14'h0, smi[0], csh[0]}, 16'h0002);
    wreg(8'h43, 8'h65);
    settle;
    chk({8'h0, fline[7:4], io[1], csl[1], csh[1], crst[1]}, 16'h005C);
    chk({11'h0, oe[1], von[1], v3[1], vpv[1], vp12[1]}, 16'h001C);
    $display("test interrupt control done");
    tally_and_finish();
  end
endmodule
